// >>> pcgb_pkg.sv
// Constants for the peripheral clock gating bank
package pcgb_pkg;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned ADDR_W       = 16;
    localparam int unsigned PERIPH_N     = 17;
    localparam int unsigned CMP_N        = 4;
    localparam int unsigned REG_N        = 3;

    localparam logic [ADDR_W-1:0] INTEG_BASE_ADDR = 16'hE400;
    localparam logic [ADDR_W-1:0] PCG1_IDX       = 16'h000D;
    localparam logic [ADDR_W-1:0] PCG2_IDX       = 16'h000E;
    localparam logic [ADDR_W-1:0] PCG3_IDX       = 16'h000F;

    // Writable bit masks; every other bit is reserved and reads zero
    localparam logic [DATA_W-1:0] PCG1_MASK      = 16'h7B41;
    localparam logic [DATA_W-1:0] PCG2_MASK      = 16'h1EAC;
    localparam logic [DATA_W-1:0] PCG3_MASK      = 16'h0080;

    localparam logic [DATA_W-1:0] PCG1_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] PCG2_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] PCG3_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_IDLE     = 16'h0000;

    // Peripheral index in the flat vectors
    localparam int unsigned P_DAC_B    = 0;
    localparam int unsigned P_DAC_A    = 1;
    localparam int unsigned P_SERIAL0  = 2;
    localparam int unsigned P_SERIAL1  = 3;
    localparam int unsigned P_QUEUED_SPI0 = 4;
    localparam int unsigned P_QUEUED_SPI1 = 5;
    localparam int unsigned P_I2C0     = 6;
    localparam int unsigned P_CAN      = 7;
    localparam int unsigned P_CMP_A    = 8;
    localparam int unsigned P_CMP_B    = 9;
    localparam int unsigned P_CMP_C    = 10;
    localparam int unsigned P_CMP_D    = 11;
    localparam int unsigned P_CYC_ADC  = 12;
    localparam int unsigned P_CRC      = 13;
    localparam int unsigned P_TIMER0   = 14;
    localparam int unsigned P_TIMER1   = 15;
    localparam int unsigned P_PWM_A0   = 16;
    localparam int unsigned P_CMP_BASE = P_CMP_A;

    // Which gate register holds each peripheral's enable (0..2)
    localparam int unsigned PERIPH_REG [PERIPH_N] = '{
        0, 0, 0, 0, 0, 0, 0, 0,
        1, 1, 1, 1, 1, 1, 1, 1,
        2
    };

    // Bit position of each peripheral's enable
    localparam int unsigned PERIPH_BIT [PERIPH_N] = '{
        14, 13, 12, 11, 9, 8, 6, 0,
        12, 11, 10, 9, 7, 5, 3, 2,
        7
    };
endpackage : pcgb_pkg

// >>> pcgb_clk_gate.sv
// Glitch-free latch-based clock gate cell
`timescale 1ns/1ps
module pcgb_clk_gate (
    input  wire logic clk_i,
    input  wire logic en_i,
    output logic      gclk_o
);
    logic en_lat;

    // Latch transparent while clock is low, so enable never changes mid-pulse
    always_latch begin
        if (!clk_i) begin
            en_lat = en_i;
        end
    end

    assign gclk_o = clk_i & en_lat;
endmodule : pcgb_clk_gate

// >>> pcgb_bus_gate.sv
// Blocks bus selects toward a peripheral whose clock is stopped
`timescale 1ns/1ps
module pcgb_bus_gate (
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    input  wire logic sel_i,
    input  wire logic run_i,
    output logic      sel_o
);
    logic sel_reg;
    logic sel_next;

    // A stopped module must see no access at all
    always_comb begin
        sel_next = sel_i & run_i;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            sel_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    assign sel_o = sel_reg;
endmodule : pcgb_bus_gate

// >>> pcgb_top.sv
// Peripheral clock gating bank: enable registers, stop override, gated clocks
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module pcgb_top #(
    parameter int unsigned PERIPH_N = pcgb_pkg::PERIPH_N
) (
    input  wire logic                          mclk_i,
    input  wire logic                          nrst_i,
    input  wire logic [pcgb_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [pcgb_pkg::DATA_W-1:0]   reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [pcgb_pkg::DATA_W-1:0]   reg_rdata_o,
    input  wire logic                          stop_mode_i,
    input  wire logic [PERIPH_N-1:0]           stop_disable_bank_i,
    input  wire logic [PERIPH_N-1:0]           periph_sel_i,
    output logic      [PERIPH_N-1:0]           periph_sel_o,
    output logic      [PERIPH_N-1:0]           periph_clk_o,
    output logic      [pcgb_pkg::CMP_N-1:0]    ref_dac_clk_o,
    output logic      [PERIPH_N-1:0]           clock_running_o
);
    import pcgb_pkg::*;

    logic [DATA_W-1:0]   periph_clock_gate_1_reg;
    logic [DATA_W-1:0]   periph_clock_gate_2_reg;
    logic [DATA_W-1:0]   periph_clock_gate_3_reg;
    logic [DATA_W-1:0]   periph_clock_gate_1_next;
    logic [DATA_W-1:0]   periph_clock_gate_2_next;
    logic [DATA_W-1:0]   periph_clock_gate_3_next;
    logic [DATA_W-1:0]   rdata_reg;
    logic [DATA_W-1:0]   rdata_next;
    logic [PERIPH_N-1:0] periph_enable;
    logic [PERIPH_N-1:0] run_reg;
    logic [PERIPH_N-1:0] run_next;
    logic [ADDR_W-1:0]   addr_off;
    logic                hit_1;
    logic                hit_2;
    logic                hit_3;

    // Address decode
    // Base plus index
    always_comb begin
        addr_off = reg_addr_i - INTEG_BASE_ADDR;
        hit_1    = (addr_off == PCG1_IDX);
        hit_2    = (addr_off == PCG2_IDX);
        hit_3    = (addr_off == PCG3_IDX);
    end

    // Write path; reserved positions keep zero whatever is written
    // Mask reserved writes
    always_comb begin
        periph_clock_gate_1_next = periph_clock_gate_1_reg;
        periph_clock_gate_2_next = periph_clock_gate_2_reg;
        periph_clock_gate_3_next = periph_clock_gate_3_reg;
        if (reg_wr_i && hit_1) begin
            periph_clock_gate_1_next = reg_wdata_i & PCG1_MASK;
        end
        if (reg_wr_i && hit_2) begin
            periph_clock_gate_2_next = reg_wdata_i & PCG2_MASK;
        end
        if (reg_wr_i && hit_3) begin
            periph_clock_gate_3_next = reg_wdata_i & PCG3_MASK;
        end
    end

    // Gate registers
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            periph_clock_gate_1_reg <= PCG1_RESET;
            periph_clock_gate_2_reg <= PCG2_RESET;
            periph_clock_gate_3_reg <= PCG3_RESET;
        end else begin
            periph_clock_gate_1_reg <= periph_clock_gate_1_next;
            periph_clock_gate_2_reg <= periph_clock_gate_2_next;
            periph_clock_gate_3_reg <= periph_clock_gate_3_next;
        end
    end

    // Read path; data stand only in the cycle after the strobe
    // Reserved bits read zero
    always_comb begin
        rdata_next = RDATA_IDLE;
        if (reg_rd_i) begin
            if (hit_1) begin
                rdata_next = periph_clock_gate_1_reg & PCG1_MASK;
            end else if (hit_2) begin
                rdata_next = periph_clock_gate_2_reg & PCG2_MASK;
            end else if (hit_3) begin
                rdata_next = periph_clock_gate_3_reg & PCG3_MASK;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rdata_reg <= RDATA_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // Flatten register bits into one enable per peripheral
    // Gate registers one to three map
    generate
        for (genvar gi = 0; gi < PERIPH_N; gi++) begin : g_map
            if (PERIPH_REG[gi] == 0) begin : g_r1
                assign periph_enable[gi] = periph_clock_gate_1_reg[PERIPH_BIT[gi]];
            end else if (PERIPH_REG[gi] == 1) begin : g_r2
                assign periph_enable[gi] = periph_clock_gate_2_reg[PERIPH_BIT[gi]];
            end else begin : g_r3
                assign periph_enable[gi] = periph_clock_gate_3_reg[PERIPH_BIT[gi]];
            end
        end
    endgenerate

    // Run decision; stop-disable only extends an enabled clock
    // Stop mode override
    always_comb begin
        run_next = periph_enable & ({PERIPH_N{~stop_mode_i}} | stop_disable_bank_i);
    end

    // Registered so the gate cells see a clean level from a flop
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            run_reg <= '0;
        end else begin
            run_reg <= run_next;
        end
    end

    assign clock_running_o = run_reg;

    // Per-peripheral clock gate and access block
    generate
        for (genvar gp = 0; gp < PERIPH_N; gp++) begin : g_periph
            pcgb_clk_gate u_gate (
                .clk_i  (mclk_i),
                .en_i   (run_reg[gp]),
                .gclk_o (periph_clk_o[gp])
            );
            pcgb_bus_gate u_bus (
                .mclk_i (mclk_i),
                .nrst_i (nrst_i),
                .sel_i  (periph_sel_i[gp]),
                .run_i  (run_reg[gp]),
                .sel_o  (periph_sel_o[gp])
            );
        end
    endgenerate

    // Reference DACs share their comparator's enable
    generate
        for (genvar gc = 0; gc < CMP_N; gc++) begin : g_ref_dac
            pcgb_clk_gate u_gate (
                .clk_i  (mclk_i),
                .en_i   (run_reg[P_CMP_BASE+gc]),
                .gclk_o (ref_dac_clk_o[gc])
            );
        end
    endgenerate
endmodule : pcgb_top

// >>> pcgb_assertions.sv
// Port-level checks for the clock gating bank
`timescale 1ns/1ps
module pcgb_assertions #(
    parameter int unsigned PERIPH_N = 17
) (
    input wire logic                mclk_i,
    input wire logic                nrst_i,
    input wire logic [15:0]         reg_addr_i,
    input wire logic [15:0]         reg_wdata_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [15:0]         reg_rdata_o,
    input wire logic                stop_mode_i,
    input wire logic [PERIPH_N-1:0] stop_disable_bank_i,
    input wire logic [PERIPH_N-1:0] periph_sel_i,
    input wire logic [PERIPH_N-1:0] periph_sel_o,
    input wire logic [PERIPH_N-1:0] periph_clk_o,
    input wire logic [3:0]          ref_dac_clk_o,
    input wire logic [PERIPH_N-1:0] clock_running_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data not idle");
    a_reserved_zero: assert property ($past(reg_rd_i && reg_addr_i == 16'hE40D)
        |-> (reg_rdata_o & 16'h84BE) == 16'h0000) else $error("reserved bit set");
    a_sel_gated: assert property (periph_sel_o ==
        ($past(periph_sel_i) & $past(clock_running_o))) else $error("select leaks");
    a_stop_off: assert property ($past(stop_mode_i) |->
        (clock_running_o & ~$past(stop_disable_bank_i)) == '0) else $error("runs in stop");
    a_zero_stops: assert property (reg_wr_i && reg_addr_i == 16'hE40D &&
        reg_wdata_i == 16'h0000 |-> ##2 clock_running_o[7:0] == 8'h00) else $error("not off");
    a_map_one: assert property (reg_wr_i && reg_addr_i == 16'hE40D ##1 !stop_mode_i
        |=> clock_running_o[0] == $past(reg_wdata_i[14], 2) &&
        clock_running_o[7] == $past(reg_wdata_i[0], 2)) else $error("map one");
    a_map_two: assert property (reg_wr_i && reg_addr_i == 16'hE40E ##1 !stop_mode_i
        |=> clock_running_o[8] == $past(reg_wdata_i[12], 2) &&
        clock_running_o[12] == $past(reg_wdata_i[7], 2)) else $error("map two");
    a_map_three: assert property (reg_wr_i && reg_addr_i == 16'hE40F ##1 !stop_mode_i
        |=> clock_running_o[16] == $past(reg_wdata_i[7], 2)) else $error("map three");
    // Sampled at the falling edge so the high phase of each gated clock is seen
    a_clk_follows: assert property (@(negedge mclk_i)
        periph_clk_o == $past(clock_running_o)) else $error("gated clock wrong");
    a_ref_pair: assert property (@(negedge mclk_i)
        ref_dac_clk_o == periph_clk_o[11:8]) else $error("reference clock split");
endmodule : pcgb_assertions

bind pcgb_top pcgb_assertions #(.PERIPH_N(PERIPH_N)) u_chk (.mclk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .stop_mode_i, .stop_disable_bank_i,
    .periph_sel_i, .periph_sel_o, .periph_clk_o, .ref_dac_clk_o, .clock_running_o);

// >>> pcgb_periph_model.sv
// Peripherals that count edges of their gated clocks
`timescale 1ns/1ps
module pcgb_periph_model #(
    parameter int N = 17
) (
    input  wire logic [N-1:0] gclk_i,
    input  wire logic [3:0]   ref_clk_i,
    output int                ticks_o [N+4]
);
    for (genvar i = 0; i < N; i++) begin : g_p
        initial ticks_o[i] = 0;
        always @(posedge gclk_i[i]) ticks_o[i] <= ticks_o[i] + 1;
    end
    for (genvar j = 0; j < 4; j++) begin : g_r
        initial ticks_o[N+j] = 0;
        always @(posedge ref_clk_i[j]) ticks_o[N+j] <= ticks_o[N+j] + 1;
    end
endmodule : pcgb_periph_model

// >>> pcgb_tb_top.sv
// Self-checking bench for the clock gating bank
`timescale 1ns/1ps
module pcgb_tb_top;
    logic        mclk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        stop_mode_i = 1'b0;
    logic [16:0] stop_disable_bank_i = 17'h00000;
    logic [16:0] periph_sel_i = 17'h00000;
    logic [16:0] periph_sel_o, periph_clk_o, clock_running_o;
    logic [15:0] reg_rdata_o;
    logic [3:0]  ref_dac_clk_o;
    int          ticks [21];
    int          err_count = 0;
    int          num_checks = 0;
    int          bitpos [17] = '{14, 13, 12, 11, 9, 8, 6, 0, 12, 11, 10, 9, 7, 5, 3, 2, 7};
    always #10 mclk_i = ~mclk_i;
    pcgb_top dut (.mclk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .stop_mode_i, .stop_disable_bank_i, .periph_sel_i, .periph_sel_o,
        .periph_clk_o, .ref_dac_clk_o, .clock_running_o);
    pcgb_periph_model peri (.gclk_i(periph_clk_o), .ref_clk_i(ref_dac_clk_o), .ticks_o(ticks));
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
        @(posedge mclk_i);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        #1 check("rdata", {1'b0, reg_rdata_o}, {1'b0, exp});
        @(posedge mclk_i);
    endtask : rd
    task automatic t_regs();
        logic [15:0] m [3] = '{default: 16'h0000};
        for (int i = 0; i < 17; i++) m[i / 8][bitpos[i]] = 1'b1;
        for (int k = 0; k < 3; k++) begin
            rd(16'(16'hE40D + k), 16'h0000);
            wr(16'(16'hE40D + k), 16'hFFFF);
            rd(16'(16'hE40D + k), m[k]);
        end
        wr(16'hE40C, 16'hFFFF);
        rd(16'hE40C, 16'h0000);
        rd(16'hE410, 16'h0000);
    endtask : t_regs
    task automatic t_map();
        int t0 [21];
        for (int i = 0; i < 17; i++) begin
            for (int k = 0; k < 3; k++) wr(16'(16'hE40D + k), (i / 8 == k) ? 16'h1 << bitpos[i] : 0);
            #1 check("run", clock_running_o, 17'h1 << i);
            t0 = ticks;
            repeat (4) @(posedge mclk_i);
            #1;
            for (int p = 0; p < 21; p++) check("ticks", 17'(ticks[p] - t0[p]),
                (p == i || (p == i + 9 && i >= 8 && i <= 11)) ? 4 : 0);
        end
    endtask : t_map
    task automatic t_stop();
        for (int k = 0; k < 3; k++) wr(16'(16'hE40D + k), 16'hFFFF);
        stop_disable_bank_i <= 17'h10081;
        stop_mode_i         <= 1'b1;
        @(posedge mclk_i);
        #1 check("stop", clock_running_o, 17'h10081);
        wr(16'hE40D, 16'h0000);
        #1 check("override", clock_running_o, 17'h10000);
        stop_mode_i <= 1'b0;
        @(posedge mclk_i);
        #1 check("wake", clock_running_o, 17'h1FF00);
    endtask : t_stop
    task automatic t_sel();
        periph_sel_i <= 17'h1FFFF;
        @(posedge mclk_i);
        #1 check("sel", periph_sel_o, 17'h1FF00);
        periph_sel_i <= 17'h00000;
    endtask : t_sel
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (10) @(posedge mclk_i);
        nrst_i <= 1'b1;
        @(posedge mclk_i);
        t_regs();
        t_map();
        t_stop();
        t_sel();
        end_sim();
    end
    initial begin
        #100000;
        err_count++;
        end_sim();
    end
endmodule : pcgb_tb_top
